// ---- src/cfgl_loader.sv ----
`timescale 1ns/100ps

// Contract
// - Preamble 0010 then 24-bit length count
// - Four more clocks after length complete configuration
// - Serial out High after header forwarded
// - Express mode ignores length, serial out Low
// - Master slow clock until rate bit; eightfold
// - Frame error halts loading, init pulled Low
// - After own frames, pass data downstream again
// - Express mode: serial out High when programmed
// - Clear while program Low, once more after
// - Program Low forces init Low
// - Wait on external init, then capture mode
// - Master waits 300 us after init High
// - Start-up when memory full, count matches
// - Express start-up after full data quota
// - Three start-up events, selectable order
// - Start-up clock runs until finished state
// - Default: done, then io, then reset release
// - Start-up clock: config or user clock
// - Done open-drain, internal pull-up by default
// - Sync-to-done modes read done; express forced
// - Held-low done stalls start-up
// - Mode pins sampled two clocks after init
module cfgl_loader #(
    parameter int FRAME_BITS = cfgl_pkg::FRAME_BITS_DEF,
    parameter int FRAME_COUNT = cfgl_pkg::FRAME_COUNT_DEF,
    parameter int EXPRESS_BYTES = cfgl_pkg::EXPRESS_BYTES_DEF,
    parameter int MASTER_WAIT = cfgl_pkg::MASTER_WAIT_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration pins
    input wire logic program_n,
    input wire logic [1:0] mode_pins,
    input wire logic data_in,
    input wire logic [7:0] data_byte,
    output logic data_out,
    // Configuration clock, driven when master
    input wire logic config_clock_i,
    output logic config_clock_o,
    output logic config_clock_oe,
    // User start-up clock net
    input wire logic user_primitive_a_clock,
    // Open-drain init and done
    input wire logic init_i,
    output logic init_o,
    output logic init_oe,
    input wire logic done_i,
    output logic done_o,
    output logic done_oe,
    output logic done_pullup,
    // Start-up events
    output logic io_active,
    output logic global_set_reset
);

    // Rising edge of a sampled level
    function automatic logic rose(input logic cur, input logic prev);
        rose = cur & ~prev;
    endfunction : rose

    cfgl_pkg::cfgl_pins_t pin_s1_ff, pin_s2_ff;
    logic lclk_d_ff, usr_ck_d_ff;
    cfgl_pkg::cfgl_state_t state_ff;
    cfgl_pkg::cfgl_ctrl_t ctrl_ff;
    cfgl_pkg::cfgl_phase_t phase_ff;
    logic [1:0] mode_ff;
    logic [12:0] wait_cnt_ff;
    logic [3:0] pre_sh_ff;
    logic [4:0] len_bit_ff;
    logic [23:0] length_ff;
    logic [31:0] ccount_ff;
    logic [8:0] fbit_ff;
    logic [10:0] frame_ff;
    logic [3:0] err_sh_ff;
    logic [13:0] byte_cnt_ff;
    logic fast_ff;
    logic frame_err_ff;
    logic [2:0] su_ph_ff;
    logic [4:0] div_cnt_ff;
    logic lclk_o_ff;
    logic div_rise;
    logic lclk_rise;
    logic su_tick;
    logic master;
    logic express;
    logic done_sync_eff;
    logic su_stall;
    logic [31:0] nxt_ccount;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic dout_ff, init_oe_ff, done_oe_ff, pullup_ff, io_ff, grst_ff;
    logic master_oe_ff;

    // Two-stage synchronisers for all outside pins
    always_ff @(posedge clk_sys) begin
        pin_s1_ff <= '{program_n: program_n, init: init_i, done: done_i,
                       lclk: config_clock_i, usr_ck: user_primitive_a_clock, din: data_in,
                       data_byte: data_byte, mode: mode_pins};
        pin_s2_ff <= pin_s1_ff;
        lclk_d_ff <= pin_s2_ff.lclk;
        usr_ck_d_ff <= pin_s2_ff.usr_ck;
    end

    assign master = (mode_ff == cfgl_pkg::MODE_MASTER);
    assign express = (mode_ff == cfgl_pkg::MODE_EXPRESS);
    assign done_sync_eff = ctrl_ff.done_sync | express;
    assign lclk_rise = master ? div_rise : rose(pin_s2_ff.lclk, lclk_d_ff);
    assign su_tick = ctrl_ff.user_clk_sel ? rose(pin_s2_ff.usr_ck, usr_ck_d_ff) :
                     lclk_rise;
    assign su_stall = done_sync_eff && (su_ph_ff >= phase_ff.done_ph) && !pin_s2_ff.done;
    assign nxt_ccount = ccount_ff + 32'h0000_0001;

    // Master clock divider, slow until the rate bit selects fast
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !master || state_ff < cfgl_pkg::ST_PREAMBLE) begin
            div_cnt_ff <= 5'h00;
            lclk_o_ff <= 1'b0;
        end else if (div_cnt_ff == 5'(fast_ff ? cfgl_pkg::LCLK_FAST_HALF - 1
                                          : cfgl_pkg::LCLK_SLOW_HALF - 1)) begin
            div_cnt_ff <= 5'h00;
            lclk_o_ff <= ~lclk_o_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
        end
    end
    assign div_rise = master && (state_ff >= cfgl_pkg::ST_PREAMBLE) && !lclk_o_ff &&
                      (div_cnt_ff == 5'(fast_ff ? cfgl_pkg::LCLK_FAST_HALF - 1
                                                : cfgl_pkg::LCLK_SLOW_HALF - 1));

    // Main configuration sequence
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !pin_s2_ff.program_n) begin
            state_ff <= cfgl_pkg::ST_CLEAR;
            wait_cnt_ff <= 13'h0000;
        end else begin
            unique case (state_ff)
                cfgl_pkg::ST_CLEAR, cfgl_pkg::ST_FINAL_CLEAR: begin
                    // One clearing pass per clear state, two in all after program rises
                    if (wait_cnt_ff == 13'(cfgl_pkg::CLEAR_PASS_CYC - 1)) begin
                        wait_cnt_ff <= 13'h0000;
                        state_ff <= (state_ff == cfgl_pkg::ST_CLEAR) ?
                                    cfgl_pkg::ST_FINAL_CLEAR : cfgl_pkg::ST_WAIT_INIT;
                    end else begin
                        wait_cnt_ff <= wait_cnt_ff + 13'h0001;
                    end
                end
                cfgl_pkg::ST_WAIT_INIT: begin
                    if (pin_s2_ff.init) begin
                        state_ff <= cfgl_pkg::ST_MODE_DLY;
                    end
                end
                cfgl_pkg::ST_MODE_DLY: begin
                    if (wait_cnt_ff == 13'(cfgl_pkg::MODE_DLY_CYC - 1)) begin
                        wait_cnt_ff <= 13'h0000;
                        state_ff <= (pin_s2_ff.mode == cfgl_pkg::MODE_MASTER) ?
                                    cfgl_pkg::ST_MASTER_WAIT : cfgl_pkg::ST_PREAMBLE;
                    end else begin
                        wait_cnt_ff <= wait_cnt_ff + 13'h0001;
                    end
                end
                cfgl_pkg::ST_MASTER_WAIT: begin
                    if (wait_cnt_ff == 13'(MASTER_WAIT - 1)) begin
                        wait_cnt_ff <= 13'h0000;
                        state_ff <= cfgl_pkg::ST_PREAMBLE;
                    end else begin
                        wait_cnt_ff <= wait_cnt_ff + 13'h0001;
                    end
                end
                cfgl_pkg::ST_PREAMBLE: begin
                    if (lclk_rise && {pre_sh_ff[2:0], pin_s2_ff.din} == cfgl_pkg::PREAMBLE_CODE) begin
                        state_ff <= cfgl_pkg::ST_LENGTH;
                    end
                end
                cfgl_pkg::ST_LENGTH: begin
                    if (lclk_rise && len_bit_ff == 5'(cfgl_pkg::LENGTH_BITS - 1)) begin
                        state_ff <= express ? cfgl_pkg::ST_EXPRESS : cfgl_pkg::ST_FRAMES;
                    end
                end
                cfgl_pkg::ST_FRAMES: begin
                    if (lclk_rise && fbit_ff == 9'(FRAME_BITS - 1)) begin
                        if ({err_sh_ff[2:0], pin_s2_ff.din} != cfgl_pkg::ERR_FIELD_OK) begin
                            state_ff <= cfgl_pkg::ST_ERROR;
                        end else if (frame_ff == 11'(FRAME_COUNT - 1)) begin
                            state_ff <= cfgl_pkg::ST_PASS;
                        end
                    end
                end
                cfgl_pkg::ST_PASS: begin
                    if (lclk_rise && nxt_ccount == {8'h00, length_ff}) begin
                        state_ff <= cfgl_pkg::ST_PRIMITIVE_A;
                    end
                end
                cfgl_pkg::ST_EXPRESS: begin
                    if (lclk_rise && byte_cnt_ff == 14'(EXPRESS_BYTES - 1)) begin
                        state_ff <= cfgl_pkg::ST_PRIMITIVE_A;
                    end
                end
                cfgl_pkg::ST_PRIMITIVE_A: begin
                    if (su_tick && !su_stall && su_ph_ff == cfgl_pkg::PH_FINISH - 3'h1) begin
                        state_ff <= cfgl_pkg::ST_FINISHED;
                    end
                end
                cfgl_pkg::ST_FINISHED, cfgl_pkg::ST_ERROR: begin
                    state_ff <= state_ff;
                end
                default: begin
                    state_ff <= cfgl_pkg::ST_CLEAR;
                end
            endcase
        end
    end

    // Mode capture two clocks after init is seen High
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_ff <= cfgl_pkg::MODE_SLAVE;
        end else if (state_ff == cfgl_pkg::ST_MODE_DLY &&
                     wait_cnt_ff == 13'(cfgl_pkg::MODE_DLY_CYC - 1)) begin
            mode_ff <= pin_s2_ff.mode;
        end
    end

    // Header shift: preamble detect and length count capture
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PREAMBLE) begin
            pre_sh_ff <= 4'hF;
            len_bit_ff <= 5'h00;
            length_ff <= 24'h00_0000;
        end else if (lclk_rise && state_ff == cfgl_pkg::ST_PREAMBLE) begin
            pre_sh_ff <= {pre_sh_ff[2:0], pin_s2_ff.din};
        end else if (lclk_rise && state_ff == cfgl_pkg::ST_LENGTH) begin
            length_ff <= {length_ff[22:0], pin_s2_ff.din};
            len_bit_ff <= len_bit_ff + 5'h01;
        end
    end

    // Configuration clock count for the length compare
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PREAMBLE) begin
            ccount_ff <= 32'h0000_0000;
        end else if (lclk_rise && state_ff < cfgl_pkg::ST_PRIMITIVE_A) begin
            ccount_ff <= nxt_ccount;
        end
    end

    // Frame bit and frame counters, error field, rate bit
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PREAMBLE) begin
            fbit_ff <= 9'h000;
            frame_ff <= 11'h000;
            err_sh_ff <= 4'h0;
            fast_ff <= 1'b0;
        end else if (lclk_rise && state_ff == cfgl_pkg::ST_FRAMES) begin
            err_sh_ff <= {err_sh_ff[2:0], pin_s2_ff.din};
            if (fbit_ff == 9'h000 && pin_s2_ff.din) begin
                fbit_ff <= 9'h000; // Leading dummy ones before the start bit
            end else if (fbit_ff == 9'(FRAME_BITS - 1)) begin
                fbit_ff <= 9'h000;
                frame_ff <= frame_ff + 11'h001;
            end else begin
                fbit_ff <= fbit_ff + 9'h001;
            end
            if (master && frame_ff == 11'h000 && fbit_ff == cfgl_pkg::RATE_BIT_POS &&
                pin_s2_ff.din) begin
                fast_ff <= 1'b1;
            end
        end
    end

    // Express byte counter
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PREAMBLE) begin
            byte_cnt_ff <= 14'h0000;
        end else if (lclk_rise && state_ff == cfgl_pkg::ST_EXPRESS) begin
            byte_cnt_ff <= byte_cnt_ff + 14'h0001;
        end
    end

    // Start-up phase counter, one phase per start-up clock edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PRIMITIVE_A || state_ff == cfgl_pkg::ST_ERROR) begin
            su_ph_ff <= 3'h0;
        end else if (state_ff == cfgl_pkg::ST_PRIMITIVE_A && su_tick && !su_stall) begin
            su_ph_ff <= su_ph_ff + 3'h1;
        end
    end

    // Start-up events at their selected phases
    always_ff @(posedge clk_sys) begin
        if (!reset_n || state_ff < cfgl_pkg::ST_PRIMITIVE_A || state_ff == cfgl_pkg::ST_ERROR) begin
            done_oe_ff <= 1'b1;
            io_ff <= 1'b0;
            grst_ff <= 1'b1;
        end else begin
            done_oe_ff <= !(su_ph_ff >= phase_ff.done_ph);
            io_ff <= (su_ph_ff >= phase_ff.io_ph);
            grst_ff <= !(su_ph_ff >= phase_ff.grst_ph);
        end
    end

    // Init pin: Low during clear, program Low and error
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            init_oe_ff <= 1'b1;
        end else begin
            init_oe_ff <= !pin_s2_ff.program_n || state_ff == cfgl_pkg::ST_CLEAR ||
                          state_ff == cfgl_pkg::ST_FINAL_CLEAR ||
                          state_ff == cfgl_pkg::ST_ERROR;
        end
    end

    // Serial data output to the next chained device
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dout_ff <= 1'b1;
        end else begin
            unique case (state_ff)
                cfgl_pkg::ST_PREAMBLE, cfgl_pkg::ST_LENGTH: begin
                    dout_ff <= express ? 1'b0 : pin_s2_ff.din;
                end
                cfgl_pkg::ST_FRAMES: begin
                    dout_ff <= 1'b1;
                end
                cfgl_pkg::ST_PASS: begin
                    dout_ff <= pin_s2_ff.din;
                end
                cfgl_pkg::ST_EXPRESS: begin
                    dout_ff <= 1'b0;
                end
                cfgl_pkg::ST_PRIMITIVE_A, cfgl_pkg::ST_FINISHED: begin
                    dout_ff <= express ? 1'b1 : pin_s2_ff.din;
                end
                default: begin
                    dout_ff <= 1'b1;
                end
            endcase
        end
    end

    // Pull-up enable follows the control register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pullup_ff <= 1'b1;
        end else begin
            pullup_ff <= ctrl_ff.pullup_en;
        end
    end

    // APB: access phase answered one cycle after it starts
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            unique case (paddr)
                cfgl_pkg::OFF_CTRL: prdata_ff <= {29'h0, ctrl_ff};
                cfgl_pkg::OFF_PHASE: prdata_ff <= {23'h0, phase_ff};
                cfgl_pkg::OFF_STATUS: prdata_ff <= {22'h0, !pin_s2_ff.done, io_ff, grst_ff,
                                                    fast_ff, mode_ff, state_ff};
                cfgl_pkg::OFF_LENGTH: prdata_ff <= {8'h00, length_ff};
                cfgl_pkg::OFF_CCOUNT: prdata_ff <= ccount_ff;
                default: pslverr_ff <= 1'b1;
            endcase
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Register writes at the completing edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_ff <= cfgl_pkg::CTRL_RESET;
            phase_ff <= cfgl_pkg::PHASE_RESET;
        end else if (psel && penable && pready_ff && pwrite) begin
            if (paddr == cfgl_pkg::OFF_CTRL) begin
                ctrl_ff <= pwdata[2:0];
            end
            if (paddr == cfgl_pkg::OFF_PHASE) begin
                phase_ff <= pwdata[8:0];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign data_out = dout_ff;
    assign config_clock_o = lclk_o_ff;
    assign config_clock_oe = master_oe_ff;
    assign init_o = 1'b0;
    assign init_oe = init_oe_ff;
    assign done_o = 1'b0;
    assign done_oe = done_oe_ff;
    assign done_pullup = pullup_ff;
    assign io_active = io_ff;
    assign global_set_reset = grst_ff;

    // Clock pin driven only by a master
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            master_oe_ff <= 1'b0;
        end else begin
            master_oe_ff <= master && state_ff >= cfgl_pkg::ST_PREAMBLE;
        end
    end

endmodule : cfgl_loader

// ---- src/cfgl_pkg.sv ----
package cfgl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PHASE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_LENGTH = 8'h0C;
    localparam logic [7:0] OFF_CCOUNT = 8'h10;

    // Bitstream layout
    localparam logic [3:0] PREAMBLE_CODE = 4'h2;
    localparam int LENGTH_BITS = 24;
    localparam int ERR_BITS = 4;
    localparam logic [3:0] ERR_FIELD_OK = 4'h6;
    localparam logic [8:0] RATE_BIT_POS = 9'h001;
    localparam int FRAME_BITS_DEF = 126;
    localparam int FRAME_COUNT_DEF = 428;
    localparam int EXPRESS_BYTES_DEF = 9884;

    // Start-up phases
    localparam logic [2:0] PH_DONE_DEF = 3'h1;
    localparam logic [2:0] PH_IO_DEF = 3'h2;
    localparam logic [2:0] PH_GRST_DEF = 3'h3;
    localparam logic [2:0] PH_FINISH = 3'h4;

    // Mode pin codes
    localparam logic [1:0] MODE_MASTER = 2'h0;
    localparam logic [1:0] MODE_SLAVE = 2'h1;
    localparam logic [1:0] MODE_EXPRESS = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int LCLK_SLOW_PERIOD_NS = 1600;
    localparam int LCLK_FAST_FACTOR = 8;
    localparam int LCLK_SLOW_HALF = LCLK_SLOW_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int LCLK_FAST_HALF = LCLK_SLOW_HALF / LCLK_FAST_FACTOR;
    localparam int MASTER_WAIT_US = 300;
    localparam int MASTER_WAIT_CYC = MASTER_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam int MODE_DLY_CYC = 2;
    localparam int CLEAR_PASS_CYC = 16;

    // Control register
    typedef struct packed {
        logic pullup_en;
        logic done_sync;
        logic user_clk_sel;
    } cfgl_ctrl_t;
    localparam cfgl_ctrl_t CTRL_RESET = '{pullup_en: 1'b1, done_sync: 1'b0, user_clk_sel: 1'b0};

    // Start-up event phases
    typedef struct packed {
        logic [2:0] grst_ph;
        logic [2:0] io_ph;
        logic [2:0] done_ph;
    } cfgl_phase_t;
    localparam cfgl_phase_t PHASE_RESET = '{grst_ph: PH_GRST_DEF, io_ph: PH_IO_DEF,
                                             done_ph: PH_DONE_DEF};

    // Pins from outside the clock domain
    typedef struct packed {
        logic program_n;
        logic init;
        logic done;
        logic lclk;
        logic usr_ck;
        logic din;
        logic [7:0] data_byte;
        logic [1:0] mode;
    } cfgl_pins_t;

    typedef enum logic [3:0] {
        ST_CLEAR = 4'h0,
        ST_FINAL_CLEAR = 4'h1,
        ST_WAIT_INIT = 4'h2,
        ST_MODE_DLY = 4'h3,
        ST_MASTER_WAIT = 4'h4,
        ST_PREAMBLE = 4'h5,
        ST_LENGTH = 4'h6,
        ST_FRAMES = 4'h7,
        ST_EXPRESS = 4'h8,
        ST_PASS = 4'h9,
        ST_PRIMITIVE_A = 4'hA,
        ST_FINISHED = 4'hB,
        ST_ERROR = 4'hC
    } cfgl_state_t;

endpackage : cfgl_pkg

// ---- test/cfgl_chk.sv ----
`timescale 1ns/100ps
module cfgl_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Watched ports
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic program_n,
    input wire logic [1:0] mode_pins,
    input wire logic init_oe,
    input wire logic done_i,
    input wire logic done_oe,
    input wire logic io_active,
    input wire logic global_set_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Bus answer timing
    ready_after_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    // Safe outputs on leaving reset, init forced Low by program and error
    reset_safe_a: assert property ($rose(reset_n) |-> init_oe && done_oe && global_set_reset)
        else $error("unsafe after reset");
    prog_init_a: assert property ($fell(program_n) |-> ##[1:6] init_oe)
        else $error("init not forced");
    init_hold_a: assert property ($rose(init_oe) && program_n |=> init_oe [*8])
        else $error("error init dropped");
    // Default start-up order, and start-up stalled by a held-low done in express mode
    done_first_a: assert property ($rose(io_active) |-> !done_oe && global_set_reset)
        else $error("io before done");
    grst_last_a: assert property ($fell(global_set_reset) |-> io_active)
        else $error("reset released early");
    io_lag_a: assert property ($fell(done_oe) |-> !io_active [*4])
        else $error("io too soon");
    done_stall_a: assert property (mode_pins == cfgl_pkg::MODE_EXPRESS && !done_i |=>
        !$rose(io_active))
        else $error("start-up not stalled");
endmodule : cfgl_chk

bind cfgl_loader cfgl_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pready(pready), .program_n(program_n), .mode_pins(mode_pins),
    .init_oe(init_oe), .done_i(done_i), .done_oe(done_oe), .io_active(io_active),
    .global_set_reset(global_set_reset));

// ---- test/cfgl_src.sv ----
`timescale 1ns/100ps
module cfgl_src (
    // Link toward the loader
    output logic lclk,
    output logic din,
    output logic [7:0] dbyte
);
    // Clock rests low between bursts
    initial begin
        lclk = 1'b0;
        din = 1'b1;
        dbyte = 8'hA5;
    end
    // Shift bits MSB first, then leave the inverse of the last bit
    task automatic send(input logic [63:0] v, input int n);
        #7;
        for (int i = n - 1; i >= 0; i--) begin
            din = v[i];
            dbyte = ~dbyte;
            #200 lclk = 1'b1;
            #200 lclk = 1'b0;
        end
        din = ~din;
    endtask : send
endmodule : cfgl_src

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic pready, pslverr, e, data_out, init_oe, done_oe, done_pullup, io_active, grst;
    logic lclk_o, lclk_oe;
    logic program_n = 1'b1, init_hold = 1'b1, done_hold = 1'b0, lclk, din;
    logic [1:0] mode_pins = cfgl_pkg::MODE_SLAVE;
    logic [7:0] dbyte;
    int error_cnt = 0, checks_done = 0, cycles = 0, mark = 0;
    // Clock and wired open-drain levels with pull-ups
    always #25 clk_sys = ~clk_sys;
    wire init_i = !(init_oe || init_hold);
    wire done_i = !(done_oe || done_hold);
    cfgl_src src (.lclk(lclk), .din(din), .dbyte(dbyte));
    cfgl_loader #(.FRAME_BITS(10), .FRAME_COUNT(2), .EXPRESS_BYTES(4), .MASTER_WAIT(20)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .program_n(program_n), .mode_pins(mode_pins), .data_in(din), .data_byte(dbyte),
        .data_out(data_out), .config_clock_i(lclk), .config_clock_o(lclk_o),
        .config_clock_oe(lclk_oe),
        .user_primitive_a_clock(1'b0), .init_i(init_i), .init_o(), .init_oe(init_oe),
        .done_i(done_i), .done_o(), .done_oe(done_oe), .done_pullup(done_pullup),
        .io_active(io_active), .global_set_reset(grst));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chko(input logic [3:0] exp);
        chk(32'({init_oe, done_oe, io_active, grst}), 32'(exp));
    endtask : chko
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys); // Idle edge between transfers
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(d & m, exp);
    endtask : rd
    // Program pulse, then wait for the loader to reach its data phase
    task automatic start_cfg;
        program_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk(32'(init_oe), 32'h1);
        rd(cfgl_pkg::OFF_STATUS, 32'hF, 32'h0);
        program_n <= 1'b1;
        repeat (80) @(posedge clk_sys);
    endtask : start_cfg
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done;
        end
    end
    // Test sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chko(4'b1101);
        rd(cfgl_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h4);
        rd(cfgl_pkg::OFF_PHASE, 32'hFFFFFFFF, 32'hD1);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, cfgl_pkg::OFF_CTRL, 32'h6);
        rd(cfgl_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h6);
        chk(32'(done_pullup), 32'h1);
        repeat (60) @(posedge clk_sys);
        rd(cfgl_pkg::OFF_STATUS, 32'hF, 32'h2);
        init_hold <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd(cfgl_pkg::OFF_STATUS, 32'h3F, 32'h15);
        $display("test reset and registers done");
        src.send(64'hF2000044, 32);
        src.send(64'h2ACAB, 19);
        repeat (6) @(posedge clk_sys);
        chko(4'b0101);
        chk(32'(data_out), 32'h1);
        src.send(64'h0, 9);
        chk(32'(data_out), 32'h0);
        src.send(64'hFF, 8);
        src.send(64'h7, 3);
        rd(cfgl_pkg::OFF_STATUS, 32'hF, 32'hA);
        src.send(64'h1, 1);
        repeat (4) @(posedge clk_sys);
        rd(cfgl_pkg::OFF_STATUS, 32'hF, 32'hB);
        chko(4'b0010);
        rd(cfgl_pkg::OFF_LENGTH, 32'hFFFFFF, 32'h44);
        $display("test serial load done");
        start_cfg;
        src.send(64'hF2000044, 32);
        src.send(64'h157, 10);
        repeat (6) @(posedge clk_sys);
        chk(32'(init_oe), 32'h1);
        rd(cfgl_pkg::OFF_STATUS, 32'hF, 32'hC);
        $display("test frame error done");
        mode_pins <= cfgl_pkg::MODE_EXPRESS;
        done_hold <= 1'b1;
        start_cfg;
        chk(32'(data_out), 32'h0);
        src.send(64'hF2000044, 32);
        src.send(64'h0, 8);
        repeat (4) @(posedge clk_sys);
        chko(4'b0001);
        done_hold <= 1'b0;
        src.send(64'h0, 4);
        repeat (4) @(posedge clk_sys);
        chko(4'b0010);
        chk(32'(data_out), 32'h1);
        $display("test express load done");
        mode_pins <= cfgl_pkg::MODE_MASTER;
        start_cfg;
        rd(cfgl_pkg::OFF_STATUS, 32'h3F, 32'h05);
        chk(32'(lclk_oe), 32'h1);
        @(posedge lclk_o);
        mark = cycles;
        @(posedge lclk_o);
        chk(32'(cycles - mark), 32'(2 * cfgl_pkg::LCLK_SLOW_HALF));
        $display("test master clock done");
        test_done;
    end
endmodule : testbench
